// >>> shared/bvir_pkg.sv
// Package: constants for the bus vectored interrupt requester
package bvir_pkg;
  // ****************************************
  // Priority levels and arbitration modes
  // ****************************************
  localparam logic [1:0] LVL_4 = 2'h0;
  localparam logic [1:0] LVL_5 = 2'h1;
  localparam logic [1:0] LVL_6 = 2'h2;
  localparam logic [1:0] LVL_7 = 2'h3;
  localparam logic       MODE_DISTRIBUTED = 1'h0;
  localparam logic       MODE_POSITION    = 1'h1;
  // Request line bit positions in the 4-bit request vector (bit0 = level 4)
  localparam int IRQ4_BIT = 0;
  localparam int IRQ5_BIT = 1;
  localparam int IRQ6_BIT = 2;
  localparam int IRQ7_BIT = 3;
  localparam logic [15:0] VECTOR_RST = 16'h0000;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS   = 10000;
  localparam int VEC_SETUP_NS    = 125;
  localparam int VEC_HOLD_NS     = 100;
  localparam int REPLY_MAX_NS    = 10000;
  localparam int REPLY_MAX_CYC   = (REPLY_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int VEC_HOLD_CYC    = (VEC_HOLD_NS * 1000) / CLK_PERIOD_PS;
endpackage

// >>> rtl/bvir_requester.sv
// Device-side interrupt requester with daisy-chain acknowledge arbitration
// Functional notes
// - Request only when condition and enable hold
// - Always assert level four line when requesting
// - Distributed level seven also drives level six line
// - Hold request lines until acknowledge arrives
// - Idle device passes acknowledge down chain
// - Distributed device checks higher request lines
// - No higher request: block chain, latch win
// - Higher request seen: keep request up, pass acknowledge
// - Position device blocks chain without checking
// - Winner replies and drives vector on lines
// - Vector stable within 125 ns of reply
// - Drop reply, remove vector within 100 ns
// - Reply within 10 us of acknowledge in
// - Equal level: nearest device on chain wins
// - Position device asserts own level plus four
`timescale 1ns/1ps
`default_nettype none
module bvir_requester #(
  parameter logic [1:0]  LEVEL  = bvir_pkg::LVL_4,       // Configured priority level
  parameter logic        MODE   = bvir_pkg::MODE_DISTRIBUTED, // Arbitration scheme
  parameter logic [15:0] VECTOR = 16'h0000                // Interrupt vector
) (
  input  wire logic        i_mclk,                  // System clock 100 MHz
  input  wire logic        i_rst,                   // Sync reset, bus initialize
  input  wire logic        i_int_cond,              // Ready, done or error
  input  wire logic        i_int_enable,            // Status register enable bit
  input  wire logic [3:0]  i_irq_lines,             // Bus request lines 7..4, high = active
  input  wire logic        i_ack_chain_in,          // Acknowledge chain in, high = active
  input  wire logic        i_data_in_strobe,        // Data-in strobe, high = active
  output logic      [3:0]  o_irq_lines_oe,          // Request line drive enables
  output logic             o_ack_chain_out,         // Acknowledge chain out
  output logic             o_reply_strobe_oe,       // Reply strobe drive enable
  output logic      [15:0] o_muxed_data_address_lines, // Vector data out
  output logic             o_muxed_data_address_oe, // Vector drive enable
  output logic             o_int_taken              // One-cycle pulse: vector read
);
  // ****************************************
  // Request line decode
  // ****************************************
  typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_PASS, ST_WIN, ST_REPLY, ST_HOLD} bvir_state_e;

  function automatic logic [3:0] assert_mask(input logic [1:0] lvl, input logic mode);
    logic [3:0] m;
    m = 4'h1;
    m[lvl] = 1'b1;
    if (mode == bvir_pkg::MODE_DISTRIBUTED && lvl == bvir_pkg::LVL_7) begin
      m[bvir_pkg::IRQ6_BIT] = 1'b1;
    end
    return m;
  endfunction

  function automatic logic [3:0] watch_mask(input logic [1:0] lvl);
    case (lvl)
      bvir_pkg::LVL_4: watch_mask = 4'h6;
      bvir_pkg::LVL_5: watch_mask = 4'h4;
      bvir_pkg::LVL_6: watch_mask = 4'h8;
      default:         watch_mask = 4'h0;
    endcase
  endfunction

  localparam logic [3:0] OWN_MASK   = assert_mask(LEVEL, MODE);
  localparam logic [3:0] WATCH_MASK = watch_mask(LEVEL);

  bvir_state_e state_q, state_d;
  logic        strobe_q, strobe_d;
  logic [7:0]  hold_cnt_q, hold_cnt_d;
  logic        higher_req;
  logic        strobe_rise;

  // Position scheme never checks other lines; arbitration rests on chain place
  assign higher_req  = (MODE == bvir_pkg::MODE_DISTRIBUTED) &&
                       |(i_irq_lines & WATCH_MASK);
  assign strobe_rise = i_data_in_strobe && !strobe_q;

  // ****************************************
  // Arbitration and vector transfer
  // ****************************************
  always_comb begin
    state_d    = state_q;
    strobe_d   = i_data_in_strobe;
    hold_cnt_d = hold_cnt_q;
    case (state_q)
      ST_IDLE: begin
        // An acknowledge whose strobe rises while idle is passed on; one begun during ST_HOLD is not
        if (strobe_rise) begin
          state_d = ST_PASS;
        end else if (i_int_cond && i_int_enable) begin
          state_d = ST_REQ;
        end
      end
      ST_REQ: begin
        // Decision is latched at the leading edge of the strobe
        if (strobe_rise) begin
          if (higher_req) begin
            state_d = ST_PASS;
          end else begin
            state_d = ST_WIN;
          end
        end
      end
      ST_PASS: begin
        // A request that lost arbitration is still pending and stays up
        if (!i_data_in_strobe) begin
          state_d = (req_oe_q || (i_int_cond && i_int_enable)) ? ST_REQ : ST_IDLE;
        end
      end
      ST_WIN: begin
        if (!i_data_in_strobe) begin
          state_d = ST_REQ;
        end else if (i_ack_chain_in) begin
          state_d = ST_REPLY;
        end
      end
      ST_REPLY: begin
        if (!i_data_in_strobe) begin
          state_d    = ST_HOLD;
          hold_cnt_d = 8'h00;
        end
      end
      ST_HOLD: begin
        hold_cnt_d = hold_cnt_q + 8'h01;
        if (hold_cnt_q >= 8'(bvir_pkg::VEC_HOLD_CYC - 1)) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q    <= ST_IDLE;
      strobe_q   <= 1'b0;
      hold_cnt_q <= 8'h00;
    end else begin
      state_q    <= state_d;
      strobe_q   <= strobe_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end

  // ****************************************
  // Output drive
  // ****************************************
  logic        req_oe_q, req_oe_d;
  logic        pass_q, pass_d;
  logic        reply_q, reply_d;
  logic        dal_oe_q, dal_oe_d;
  logic        taken_q, taken_d;

  always_comb begin
    // Request held from start through the win, dropped once the vector goes
    req_oe_d = (state_d == ST_REQ) || (state_d == ST_WIN) ||
               ((state_d == ST_PASS) && (state_q == ST_REQ || req_oe_q));
    pass_d   = (state_d == ST_PASS) && i_ack_chain_in;
    reply_d  = (state_d == ST_REPLY);
    dal_oe_d = (state_d == ST_REPLY) || (state_d == ST_HOLD);
    taken_d  = (state_q == ST_REPLY) && (state_d == ST_HOLD);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      req_oe_q <= 1'b0;
      pass_q   <= 1'b0;
      reply_q  <= 1'b0;
      dal_oe_q <= 1'b0;
      taken_q  <= 1'b0;
    end else begin
      req_oe_q <= req_oe_d;
      pass_q   <= pass_d;
      reply_q  <= reply_d;
      dal_oe_q <= dal_oe_d;
      taken_q  <= taken_d;
    end
  end

  assign o_irq_lines_oe             = req_oe_q ? OWN_MASK : 4'h0;
  assign o_ack_chain_out            = pass_q;
  assign o_reply_strobe_oe          = reply_q;
  // Vector driven in the same cycle as reply, well inside the setup limit
  assign o_muxed_data_address_lines = dal_oe_q ? VECTOR : bvir_pkg::VECTOR_RST;
  assign o_muxed_data_address_oe    = dal_oe_q;
  assign o_int_taken                = taken_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  AST_LEVEL_FOUR: assert property (|o_irq_lines_oe |-> o_irq_lines_oe[bvir_pkg::IRQ4_BIT])
    else $error("Level four line not driven with request");
  AST_SEVEN_SIX: assert property (o_irq_lines_oe[bvir_pkg::IRQ7_BIT] |->
    (o_irq_lines_oe[bvir_pkg::IRQ6_BIT] == (MODE == bvir_pkg::MODE_DISTRIBUTED)))
    else $error("Level seven request with wrong level six drive");
  AST_NO_REQ_DISABLED: assert property ((state_q == ST_IDLE && !(i_int_cond && i_int_enable))
    |=> !(state_q == ST_REQ))
    else $error("Request began without enable");
  AST_HOLD_REQ: assert property ((state_q == ST_REQ && !strobe_rise) |=> |o_irq_lines_oe)
    else $error("Request dropped before acknowledge");
  AST_NO_PASS_WIN: assert property (state_q == ST_WIN |-> !o_ack_chain_out)
    else $error("Chain passed while winning");
  AST_WITHDRAW: assert property ((state_q == ST_REQ && strobe_rise && higher_req) |=> state_q == ST_PASS)
    else $error("Did not withdraw on higher request");
  AST_PASS_IDLE: assert property ((state_q == ST_PASS && i_ack_chain_in && i_data_in_strobe)
    |=> o_ack_chain_out)
    else $error("Idle device did not pass acknowledge");
  AST_REPLY_VEC: assert property ($rose(o_reply_strobe_oe) |-> o_muxed_data_address_oe
    && o_muxed_data_address_lines == VECTOR)
    else $error("Vector not present with reply");
  AST_REPLY_FAST: assert property ((state_q == ST_WIN && i_ack_chain_in && i_data_in_strobe)
    |-> ##[1:2] o_reply_strobe_oe)
    else $error("Reply late after acknowledge");
  AST_REMOVE_VEC: assert property ($fell(o_reply_strobe_oe) |-> ##[1:10] !o_muxed_data_address_oe)
    else $error("Vector held too long after reply");

  CV_WIN: cover property (state_q == ST_WIN ##[1:5] o_reply_strobe_oe);
  CV_PASS: cover property (o_ack_chain_out);
  CV_TAKEN: cover property (o_int_taken);
endmodule // bvir_requester
`default_nettype wire

// >>> tb/bvir_cpu_model.sv
// Processor-side model: issues the interrupt acknowledge and reads the vector
`timescale 1ns/1ps
`default_nettype none
module bvir_cpu_model (
  input  wire logic        i_mclk,   // System clock
  input  wire logic        i_reply,  // Reply strobe wire
  input  wire logic [15:0] i_data,   // Data/address wire
  output logic             o_strobe, // Data-in strobe
  output logic             o_ack     // Acknowledge into the chain
);
  // ****************************************
  // Acknowledge sequence
  // ****************************************
  initial begin
    o_strobe = 1'b0;
    o_ack    = 1'b0;
  end
  // Callers only acknowledge with a request pending and no other cycle running
  task automatic acknowledge(input int gap, output logic [15:0] vec, output bit ok);
    int n;
    n   = 0;
    ok  = 1'b0;
    vec = 16'h0000;
    @(posedge i_mclk);
    #1 o_strobe = 1'b1;
    repeat (gap) @(posedge i_mclk);
    #1 o_ack = 1'b1;
    while (i_reply !== 1'b1 && n < 1000) begin
      @(posedge i_mclk);
      #1 n++;
    end
    if (n < 1000) begin
      ok = 1'b1;
      repeat (13) @(posedge i_mclk);
      vec = i_data;
    end
    #1 o_strobe = 1'b0;
    o_ack = 1'b0;
  endtask
endmodule // bvir_cpu_model
`default_nettype wire

// >>> tb/testbench.sv
// Testbench: two requesters on one chain behind the processor model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module testbench;
  // ****************************************
  // Bus wiring
  // ****************************************
  logic        clk = 1'b0, rst = 1'b1, cond1 = 1'b0, en1 = 1'b0, cond2 = 1'b0, en2 = 1'b0;
  logic [3:0]  others = 4'h0, oe1, oe2;
  logic        r1, r2, voe1, voe2, chain1, strobe, ack, taken1;
  logic [15:0] d1, d2;
  wire  [3:0]  lines = oe1 | oe2 | others;
  wire         reply = r1 | r2;
  int          n_fail = 0, comparisons = 0;
  always #5 clk = ~clk;
  bvir_requester #(.LEVEL(bvir_pkg::LVL_5), .MODE(bvir_pkg::MODE_DISTRIBUTED), .VECTOR(16'h0054)) i_dut (
    .i_mclk(clk), .i_rst(rst), .i_int_cond(cond1), .i_int_enable(en1), .i_irq_lines(lines),
    .i_ack_chain_in(ack), .i_data_in_strobe(strobe), .o_irq_lines_oe(oe1), .o_ack_chain_out(chain1),
    .o_reply_strobe_oe(r1), .o_muxed_data_address_lines(d1), .o_muxed_data_address_oe(voe1), .o_int_taken(taken1));
  bvir_requester #(.LEVEL(bvir_pkg::LVL_7), .MODE(bvir_pkg::MODE_POSITION), .VECTOR(16'h00c0)) i_dut2 (
    .i_mclk(clk), .i_rst(rst), .i_int_cond(cond2), .i_int_enable(en2), .i_irq_lines(lines),
    .i_ack_chain_in(chain1), .i_data_in_strobe(strobe), .o_irq_lines_oe(oe2), .o_ack_chain_out(),
    .o_reply_strobe_oe(r2), .o_muxed_data_address_lines(d2), .o_muxed_data_address_oe(voe2), .o_int_taken());
  bvir_cpu_model i_cpu (.i_mclk(clk), .i_reply(reply), .i_data(d1 | d2), .o_strobe(strobe), .o_ack(ack));
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic run_ack(input int gap, input logic [15:0] ev, input logic ec);
    logic [15:0] v;
    bit          ok;
    fork
      i_cpu.acknowledge(gap, v, ok);
      begin
        repeat (gap) @(posedge clk);
        #2 `CHK("irq_held", 4'h3, oe1)
        repeat (6) @(posedge clk);
        #2 `CHK("chain_out", ec, chain1)
      end
    join
    `CHK("reply_seen", 1'b1, ok)
    `CHK("vector", ev, v)
    @(posedge clk);
    #1 `CHK("taken_pulse", !ec, taken1)
    @(posedge clk);
    #1 `CHK("taken_low", 1'b0, taken1)
    @(posedge clk);
    #1 `CHK("reply_drop", 1'b0, reply)
    // Vector must be off the lines within 100 ns of the reply dropping
    repeat (8) @(posedge clk);
    #1 `CHK("vec_oe_drop", 1'b0, voe1 | voe2)
  endtask
  task automatic s_enable_and_win;
    cond1 = 1'b1;
    repeat (4) @(posedge clk);
    #1 `CHK("irq_no_enable", 4'h0, oe1)
    en1 = 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("irq_lvl5", 4'h3, oe1)
    cond1 = 1'b0;
    run_ack(23, 16'h0054, 1'b0);
    `CHK("irq_after_win", 4'h0, oe1)
  endtask
  task automatic s_nearest_wins;
    cond1 = 1'b1;
    cond2 = 1'b1;
    en2   = 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("irq_both", 4'hb, lines)
    cond1 = 1'b0;
    cond2 = 1'b0;
    run_ack(23, 16'h0054, 1'b0);
    `CHK("irq_loser_held", 4'h9, oe2)
  endtask
  task automatic s_higher_pass;
    cond1 = 1'b1;
    cond2 = 1'b1;
    en2 = 1'b1;
    others = 4'h4;
    repeat (3) @(posedge clk);
    #1 `CHK("irq_pos7", 4'h9, oe2)
    cond1 = 1'b0;
    cond2 = 1'b0;
    run_ack(60, 16'h00c0, 1'b1);
    `CHK("irq_pass_held", 4'h3, oe1)
    others = 4'h0;
  endtask
  // ****************************************
  // Sequence and verdict
  // ****************************************
  task automatic final_report;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    s_enable_and_win();
    s_nearest_wins();
    s_higher_pass();
    final_report();
  end
  initial begin
    #50000;
    n_fail++;
    final_report();
  end
endmodule // testbench
`default_nettype wire
